// ---- design/tcp_high_timer.sv ----
// module: standard-speed scl high-period counter
`timescale 1ns/1ps
module tcp_high_timer (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  // control
  input  wire logic        start_i,
  input  wire logic [15:0] count_i,
  // status
  output logic             busy_o,
  output logic             done_o
);
  typedef struct packed {
    logic [16:0] cnt;
    logic        busy;
    logic        done;
  } tcp_tmr_s;
  tcp_tmr_s st;
  tcp_tmr_s next_st;
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      if (st.cnt == 17'h00000) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 17'h00001;
      end
    end else if (start_i) begin
      // high period lasts programmed count plus the fixed eight cycles
      next_st.cnt = {1'b0, count_i} + tcp_pkg::HCNT_EXTRA - 17'h00001; // RULE15
      next_st.busy = 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end
  assign busy_o = st.busy;
  assign done_o = st.done;
endmodule

// ---- design/tcp_pkg.sv ----
// package: register map, field layout, reset values and states of the two-wire target/command port
// What this block does
// RULE1: enable 0 ignores select, normal addressing
// RULE2: select 0 general call, 1 start byte
// RULE3: after general call, read sets abort
// RULE4: general-call mode holds until enable cleared
// RULE5: target address used; ignored for general call
// RULE6: software writes target once for start byte
// RULE7: self-addressing is simplex loopback only
// RULE8: own address 10 bits; 7-bit uses low seven
// RULE9: own address writable only while disabled
// RULE10: command bit sets master direction only
// RULE11: slave transmit data written with command 0
// RULE12: read command after read request aborts; the code aborts only in master mode, a slave-mode read command is pushed
// RULE13: master read during read request: drop, abort
// RULE14: data byte sent on write; read returns received
// RULE15: high period counts programmed value plus eight
// RULE16: software programs high count for 4 us
// RULE17: addresses reset 0x055, high count 0x033A
// RULE18: speed 1 standard, 2 fast, master only
// RULE19: 7-bit slave ignores 10-bit transactions
// RULE20: port write pushes one command entry
package tcp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_TARGET  = 8'h04;
  localparam logic [7:0] ADDR_OWN     = 8'h08;
  localparam logic [7:0] ADDR_DATA    = 8'h10;
  localparam logic [7:0] ADDR_SS_HCNT = 8'h14;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  // target address fields
  localparam int TGT_ENA_BIT = 11;
  localparam int TGT_SEL_BIT = 10;
  localparam int ADDR_MSB    = 9;
  localparam int ADDR7_MSB   = 6;
  // data/command fields
  localparam int CMD_BIT     = 8;
  localparam int DATA_MSB    = 7;
  // control fields
  localparam int CTL_ENA_BIT   = 0;
  localparam int CTL_SPD_LSB   = 1;
  localparam int CTL_SLV10_BIT = 3;
  localparam int CTL_MST10_BIT = 4;
  // status fields
  localparam int ST_ABORT_BIT = 0;
  localparam int ST_GC_BIT    = 1;
  localparam int ST_SPD_BIT   = 2;
  // reset values
  localparam logic [11:0] TARGET_RST = 12'h055;
  localparam logic [9:0]  OWN_RST    = 10'h055;
  localparam logic [15:0] SS_HCNT_RST = 16'h033A;
  localparam logic [4:0]  CTRL_RST   = 5'h05;
  // speed codes
  localparam logic [1:0] SPD_STD  = 2'h1;
  localparam logic [1:0] SPD_FAST = 2'h2;
  // fixed extra cycles in the high period
  localparam logic [16:0] HCNT_EXTRA = 17'h00008;
  typedef enum logic [1:0] {TCP_IDLE, TCP_HIGH, TCP_LOW} tcp_phase_e;
endpackage

// ---- design/tcp_top.sv ----
// module: target address, own address, data/command port and high-count registers
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module tcp_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // controller side, same clock
  input  wire logic        master_mode_i,
  input  wire logic        read_request_i,
  input  wire logic        slave_10bit_req_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  output logic             rx_pop_o,
  // transmit fifo push
  output logic             tx_push_o,
  output logic [8:0]       tx_entry_o,
  // bus control outputs
  output logic             gen_call_o,
  output logic             start_byte_o,
  output logic [9:0]       master_addr_o,
  output logic [9:0]       slave_match_addr_o,
  output logic             slave_ignore_10bit_o,
  output logic             loopback_simplex_o,
  output logic             std_speed_o,
  output logic             transmit_abort_flag_o,
  // high-period timer
  input  wire logic        scl_high_start_i,
  output logic             scl_high_busy_o,
  output logic             scl_high_done_o
);
  typedef struct packed {
    logic [11:0] target;
    logic [9:0]  own;
    logic [15:0] hcnt;
    logic [4:0]  ctrl;
    logic        abort;
    logic        gc_mode;
    logic        rd_req_seen;
    logic        ack;
    logic [31:0] rdata;
    logic        push;
    logic [8:0]  entry;
    logic        pop;
  } tcp_regs_s;
  tcp_regs_s st;
  tcp_regs_s next_st;
  logic        access;
  logic        take;
  logic        enabled;
  logic        special;
  logic        is_gc;
  logic        cmd_read;
  logic [31:0] rd_mux;
  logic [1:0]  speed;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  assign access   = (avs_read_i || avs_write_i) && !st.ack;
  assign take     = (avs_read_i || avs_write_i) && st.ack;
  assign enabled  = st.ctrl[tcp_pkg::CTL_ENA_BIT];
  assign special  = st.target[tcp_pkg::TGT_ENA_BIT];
  assign is_gc    = special && !st.target[tcp_pkg::TGT_SEL_BIT]; // RULE1 RULE2
  assign cmd_read = avs_writedata_i[tcp_pkg::CMD_BIT];
  assign speed    = st.ctrl[tcp_pkg::CTL_SPD_LSB +: 2];

  always_comb begin
    rd_mux = 32'h00000000;
    if (avs_address_i == tcp_pkg::ADDR_TARGET) begin
      rd_mux[11:0] = st.target;
    end else if (avs_address_i == tcp_pkg::ADDR_OWN) begin
      rd_mux[9:0] = st.own;
    end else if (avs_address_i == tcp_pkg::ADDR_DATA) begin
      rd_mux[tcp_pkg::DATA_MSB:0] = rx_byte_i; // RULE14
    end else if (avs_address_i == tcp_pkg::ADDR_SS_HCNT) begin
      rd_mux[15:0] = st.hcnt;
    end else if (avs_address_i == tcp_pkg::ADDR_CTRL) begin
      rd_mux[4:0] = st.ctrl;
    end else if (avs_address_i == tcp_pkg::ADDR_STATUS) begin
      rd_mux[tcp_pkg::ST_ABORT_BIT] = st.abort;
      rd_mux[tcp_pkg::ST_GC_BIT]    = st.gc_mode;
      rd_mux[tcp_pkg::ST_SPD_BIT]   = std_speed_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register update
  always_comb begin
    next_st = st;
    next_st.ack  = access;
    next_st.push = 1'b0;
    next_st.pop  = 1'b0;
    if (read_request_i) begin
      next_st.rd_req_seen = 1'b1;
    end
    // general-call mode persists until special enable is cleared
    if (!special) begin
      next_st.gc_mode = 1'b0; // RULE4
    end
    // read data is latched in the wait cycle so it stands at the accepting edge
    if (access && avs_read_i) begin
      next_st.rdata = rd_mux;
    end
    // side effects land only at the edge that sees waitrequest low
    if (take && avs_read_i) begin
      if (avs_address_i == tcp_pkg::ADDR_DATA && rx_valid_i) begin
        next_st.pop = 1'b1;
      end else if (avs_address_i == tcp_pkg::ADDR_STATUS) begin
        // the status read clears abort; only data writes set it, so no new abort lands in this cycle
        next_st.abort = 1'b0;
      end
    end else if (take && avs_write_i) begin
      if (avs_address_i == tcp_pkg::ADDR_TARGET) begin
        if (avs_byteenable_i[0]) begin
          next_st.target[7:0] = avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
          next_st.target[11:8] = avs_writedata_i[11:8];
        end
      end else if (avs_address_i == tcp_pkg::ADDR_OWN) begin
        if (!enabled) begin // RULE9
          if (avs_byteenable_i[0]) begin
            next_st.own[7:0] = avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1]) begin
            next_st.own[9:8] = avs_writedata_i[9:8];
          end
        end
      end else if (avs_address_i == tcp_pkg::ADDR_SS_HCNT) begin
        if (avs_byteenable_i[0]) begin
          next_st.hcnt[7:0] = avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
          next_st.hcnt[15:8] = avs_writedata_i[15:8];
        end
      end else if (avs_address_i == tcp_pkg::ADDR_CTRL) begin
        if (avs_byteenable_i[0]) begin
          next_st.ctrl = avs_writedata_i[4:0];
          // only the two legal speed codes are kept
          if (avs_writedata_i[2:1] != tcp_pkg::SPD_STD
              && avs_writedata_i[2:1] != tcp_pkg::SPD_FAST) begin
            next_st.ctrl[tcp_pkg::CTL_SPD_LSB +: 2] = speed; // RULE18
          end
        end
      end else if (avs_address_i == tcp_pkg::ADDR_DATA && enabled
                   && avs_byteenable_i[1:0] == 2'h3) begin
        if (master_mode_i && cmd_read && (read_request_i || st.rd_req_seen)) begin
          next_st.abort = 1'b1; // RULE12 RULE13
        end else if (master_mode_i && cmd_read && (is_gc || st.gc_mode)) begin
          next_st.abort = 1'b1; // RULE3
        end else begin
          // slave mode passes the command bit through but it steers nothing
          next_st.push  = 1'b1; // RULE20 RULE10
          next_st.entry = avs_writedata_i[8:0]; // RULE14
          if (master_mode_i && is_gc) begin
            next_st.gc_mode = 1'b1;
          end
        end
        // a read request arriving in the same cycle wins over the clear
        if (!master_mode_i && !read_request_i) begin
          next_st.rd_req_seen = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st        <= '0;
      st.target <= tcp_pkg::TARGET_RST; // RULE17
      st.own    <= tcp_pkg::OWN_RST;
      st.hcnt   <= tcp_pkg::SS_HCNT_RST;
      st.ctrl   <= tcp_pkg::CTRL_RST;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // high-period timer, used only at standard speed
  tcp_high_timer u_high (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .start_i    (scl_high_start_i && std_speed_o),
    .count_i    (st.hcnt),
    .busy_o     (scl_high_busy_o),
    .done_o     (scl_high_done_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_waitrequest_o     = (avs_read_i || avs_write_i) && !st.ack;
  assign avs_readdata_o        = st.rdata;
  assign tx_push_o             = st.push;
  assign tx_entry_o            = st.entry;
  assign rx_pop_o              = st.pop;
  assign gen_call_o            = is_gc || st.gc_mode;
  assign start_byte_o          = special && st.target[tcp_pkg::TGT_SEL_BIT]; // RULE2
  assign master_addr_o         = st.target[tcp_pkg::ADDR_MSB:0]; // RULE5
  // loopback shares fifos so only one direction at a time
  assign loopback_simplex_o    = st.target[tcp_pkg::ADDR_MSB:0] == st.own; // RULE7
  assign slave_match_addr_o    = st.ctrl[tcp_pkg::CTL_SLV10_BIT] ? st.own
                                 : {3'h0, st.own[tcp_pkg::ADDR7_MSB:0]}; // RULE8
  assign slave_ignore_10bit_o  = !st.ctrl[tcp_pkg::CTL_SLV10_BIT] && slave_10bit_req_i; // RULE19
  assign std_speed_o           = master_mode_i && speed == tcp_pkg::SPD_STD; // RULE18
  assign transmit_abort_flag_o = st.abort;
endmodule

// ---- sim/tcp_asserts.sv ----
// checker: bus handshake, push source, special commands and timer
`timescale 1ns/1ps
module tcp_asserts (
  // watched ports
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       master_mode_i,
  input wire logic       tx_push_o,
  input wire logic [8:0] tx_entry_o,
  input wire logic       gen_call_o,
  input wire logic       start_byte_o,
  input wire logic       std_speed_o,
  input wire logic       scl_high_busy_o,
  input wire logic       scl_high_done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic acc_data;
  always_ff @(posedge core_clk_i) begin
    acc_data <= ~rst_i & avs_write_i & ~avs_waitrequest_o & (avs_address_i == 8'h10);
  end
  wait_first_a: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait cycle");
  wait_one_a: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("wait too long");
  push_src_a: assert property (tx_push_o |-> acc_data)
    else $error("push without data write");
  gc_noread_a: assert property (tx_push_o && tx_entry_o[8] && $past(master_mode_i)
    |-> !$past(gen_call_o)) else $error("read pushed in general call");
  special_excl_a: assert property (!(gen_call_o && start_byte_o))
    else $error("both special commands");
  std_master_a: assert property (std_speed_o |-> master_mode_i)
    else $error("speed outside master");
  done_busy_a: assert property (scl_high_done_o |-> $past(scl_high_busy_o))
    else $error("done without busy");
  done_pulse_a: assert property (scl_high_done_o |=> !scl_high_done_o)
    else $error("done too long");
endmodule
bind tcp_top tcp_asserts i_chk (.*);

// ---- sim/tcp_partner.sv ----
// model of the remote bus party: read requests and received bytes
`timescale 1ns/1ps
module tcp_partner (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // commands from the bench, pop from the block
  input  wire logic       ask_i,
  input  wire logic       send_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       pop_i,
  // towards the block
  output logic            read_request_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o
);
  // a consumed byte is inverted so a stale value never reads as fresh
  always_ff @(posedge core_clk_i) begin
    read_request_o <= ask_i & ~rst_i;
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_byte_o  <= 8'h00;
    end else if (send_i) begin
      rx_valid_o <= 1'b1;
      rx_byte_o  <= byte_i;
    end else if (pop_i) begin
      rx_valid_o <= 1'b0;
      rx_byte_o  <= ~rx_byte_o;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// testbench: registers, command port, aborts and high timer
`timescale 1ns/1ps
module testbench;
  logic        core_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, ask = 1'b0, send = 1'b0;
  logic        avs_read_i = 1'b0, avs_write_i = 1'b0, master_mode_i = 1'b0;
  logic        slave_10bit_req_i = 1'b0, scl_high_start_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00, rx_b = 8'h00, rx_byte_i;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic        avs_waitrequest_o, rx_pop_o, tx_push_o, gen_call_o, start_byte_o;
  logic        slave_ignore_10bit_o, loopback_simplex_o, std_speed_o, transmit_abort_flag_o;
  logic        scl_high_busy_o, scl_high_done_o, rx_valid_i, read_request_i;
  logic [9:0]  master_addr_o, slave_match_addr_o, own;
  logic [8:0]  tx_entry_o, last, d;
  int          error_cnt = 0, total_checks = 0, pushes = 0, n;
  tcp_top i_dut (.*);
  tcp_partner i_far (.core_clk_i(core_clk_i), .rst_i(rst_i), .ask_i(ask), .send_i(send),
    .byte_i(rx_b), .pop_i(rx_pop_o), .read_request_o(read_request_i),
    .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (tx_push_o === 1'b1) begin
      pushes <= pushes + 1;
      last   <= tx_entry_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    avs_address_i   <= a;
    avs_writedata_i <= v;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (k >= 20) chk(0, 1, "no answer");
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // push count is read one edge late so the monitor update has landed
  task automatic put(input logic [8:0] v, input int p);
    n = pushes;
    bus(1'b1, 8'h10, {23'h0, v});
    @(posedge core_clk_i);
    chk(pushes - n, p, "push count");
    if (p == 1) chk(last, v, "entry");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(78420));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    bus(1'b0, 8'h04, 0); chk(q, 32'h055, "target");
    bus(1'b0, 8'h08, 0); chk(q, 32'h055, "own");
    bus(1'b0, 8'h14, 0); chk(q, 32'h033A, "hcnt");
    bus(1'b0, 8'h1C, 0); chk(q, 0, "unmapped");
    own = 10'($urandom) | 10'h080;
    bus(1'b1, 8'h08, own);
    bus(1'b0, 8'h08, 0); chk(q, 32'h055, "own locked");
    bus(1'b1, 8'h00, 32'h04);
    bus(1'b1, 8'h08, own);
    bus(1'b0, 8'h08, 0); chk(q, own, "own");
    chk(slave_match_addr_o, {3'h0, own[6:0]}, "match");
    slave_10bit_req_i <= 1'b1;
    @(posedge core_clk_i);
    chk(slave_ignore_10bit_o, 1, "ignore 10-bit");
    bus(1'b1, 8'h00, 32'h0C);
    chk(slave_ignore_10bit_o, 0, "accept 10-bit");
    chk(slave_match_addr_o, own, "match 10-bit");
    slave_10bit_req_i <= 1'b0;
    bus(1'b1, 8'h00, 32'h05);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h04, {i[1:0], own});
      chk(gen_call_o, i == 2, "gc");
      chk(start_byte_o, i == 3, "sb");
      chk(loopback_simplex_o, 1, "loop");
      if (i < 2) chk(master_addr_o, own, "maddr");
    end
    master_mode_i <= 1'b1;
    bus(1'b1, 8'h04, {2'b00, own ^ 10'h001});
    chk(loopback_simplex_o, 0, "no loop");
    repeat (6) begin
      d = 9'($urandom);
      put(d, 1);
    end
    $display("test commands done");
    bus(1'b1, 8'h04, 32'h800);
    put(9'h0A5, 1);
    put(9'h100, 0);
    chk(transmit_abort_flag_o, 1, "abort");
    put(9'h05A, 1);
    bus(1'b0, 8'h18, 0); chk(q & 32'h3, 32'h3, "gc status");
    bus(1'b1, 8'h04, 32'h055);
    bus(1'b0, 8'h18, 0); chk(q & 32'h3, 0, "gc off");
    ask <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    put(9'h100, 0);
    ask <= 1'b0;
    chk(transmit_abort_flag_o, 1, "rq abort");
    master_mode_i <= 1'b0;
    put(9'h033, 1);
    master_mode_i <= 1'b1;
    put(9'h1FF, 1);
    $display("test aborts done");
    rx_b <= 8'($urandom);
    send <= 1'b1;
    @(posedge core_clk_i);
    send <= 1'b0;
    @(posedge core_clk_i);
    bus(1'b0, 8'h10, 0); chk(q[7:0], rx_b, "rx");
    @(posedge core_clk_i);
    chk(rx_valid_i, 0, "rx pop");
    bus(1'b1, 8'h00, 32'h03);
    chk(std_speed_o, 1, "std");
    // 72 cycles plus the fixed eight give 4 us at 50 ns
    d = 9'(72 + $urandom % 8);
    bus(1'b1, 8'h14, {23'h0, d});
    scl_high_start_i <= 1'b1;
    @(posedge core_clk_i);
    scl_high_start_i <= 1'b0;
    n = 0;
    for (int c = 0; c < 200 && scl_high_done_o !== 1'b1; c++) begin
      @(posedge core_clk_i);
      if (scl_high_busy_o === 1'b1 && scl_high_done_o !== 1'b1) n++;
    end
    chk(n, d + 8, "high period");
    chk(n * 50 >= 4000, 1, "high at least 4 us");
    bus(1'b1, 8'h00, 32'h07);
    chk(std_speed_o, 1, "bad speed");
    bus(1'b1, 8'h00, 32'h05);
    chk(std_speed_o, 0, "fast");
    $display("test speed done");
    stop_test();
  end
endmodule
